// ===== fdk_handler.sv
`timescale 1ns/1ps
module fdk_handler
  import fdk_pkg::*;
#(
  parameter logic [16:0] COUNT_CYC = 17'(GLITCH_COUNT_CYC),
  parameter logic [23:0] EIGHTH_CYC = 24'(TICK_CYC)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] key_in,
  input wire logic [3:0] tach_in,
  input wire logic [31:0] temp_crc_err,
  output logic [3:0] fan_drive,
  output logic lcd_wr,
  output logic lcd_ctrl_sel,
  output logic [7:0] lcd_data,
  output logic key_evt_vld,
  output logic [5:0] key_press_evt,
  output logic [5:0] key_release_evt,
  output logic [15:0] slot_show
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] cmd_typ;
    logic [4:0] cmd_len;
    logic [6:0][7:0] cmd_dat;
    logic go;
    logic [7:0] rsp_typ;
    logic [4:0] rsp_len;
    logic [4:0][7:0] rsp_dat;
    logic rsp_vld;
    fdk_cfg_type cfg;
    fdk_cfg_type boot;
    logic [7:0][1:0] show;
    logic [5:0] key_s1;
    logic [5:0] key_s2;
    logic [5:0] key_s3;
    logic [5:0] held;
    logic [5:0] since_pr;
    logic [5:0] since_rl;
    logic evt_vld;
    logic [5:0] evt_pr;
    logic [5:0] evt_rl;
    logic [3:0][7:0] fan_pwr;
    logic [3:0] fs_mask;
    logic [7:0] fs_tmo;
    logic [7:0] fs_cnt;
    logic [3:0] fs_act;
    logic [16:0] sub_cnt;
    logic [6:0] pwm_cnt;
    logic [23:0] tick_cnt;
    logic [1:0] phase;
    logic [3:0] fan_on;
    logic [3:0][7:0] gl_cnt;
    logic [3:0] tach_s1;
    logic [3:0] tach_s2;
    logic [3:0] tach_s3;
    logic [3:0] tach_lvl;
    logic [3:0][7:0] edges;
    logic [3:0][7:0] tach_last;
    logic lcd_wr;
    logic lcd_sel;
    logic [7:0] lcd_dat;
  } fdk_state_type;

  fdk_state_type s_q;
  fdk_state_type s_d;

  function automatic logic [31:0] slot_word(input fdk_cfg_type c, input logic [2:0] k);
    slot_word = {c.slot_en[k], c.slot_kind[k], c.slot_idx[k], 5'h00, c.slot_dig[k],
                 c.slot_col[k], 3'h0, c.slot_row[k], 2'h0, c.slot_aux[k]};
  endfunction : slot_word

  // ==========================================================
  // next state
  always_comb begin
    logic setup;
    logic acc;
    logic cnt_tick;
    logic eighth_tick;
    logic [6:0][7:0] d;
    logic [2:0] sl;
    logic [3:0] shown_fan;
    logic [3:0] forced;
    logic [5:0] agree;
    logic [5:0] nheld;
    logic [5:0] pr;
    logic [5:0] rl;
    logic [3:0] tagree;
    logic [3:0] tlvl;
    logic slot_ok;
    setup = 1'b0;
    acc = 1'b0;
    cnt_tick = 1'b0;
    eighth_tick = 1'b0;
    d = s_q.cmd_dat;
    sl = s_q.cmd_dat[0][2:0];
    shown_fan = 4'h0;
    forced = 4'h0;
    slot_ok = 1'b0;
    agree = ~(s_q.key_s2 ^ s_q.key_s3);
    nheld = (agree & s_q.key_s3) | (~agree & s_q.held);
    pr = nheld & ~s_q.held;
    rl = s_q.held & ~nheld;
    tagree = ~(s_q.tach_s2 ^ s_q.tach_s3);
    tlvl = (tagree & s_q.tach_s3) | (~tagree & s_q.tach_lvl);
    s_d = s_q;
    s_d.go = 1'b0;
    s_d.lcd_wr = 1'b0;
    s_d.evt_vld = 1'b0;

    // apb: zero wait states, answer in the access cycle
    setup = psel & ~penable;
    acc = psel & penable & s_q.pready;
    s_d.pready = setup;
    // error flag stands only in the access cycle, like pready
    s_d.pslverr = 1'b0;
    if (setup) begin
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h0000_0000;
      if (paddr[11:5] == SLOT_PAGE && paddr[1:0] == 2'h0) begin
        if (!pwrite) begin
          s_d.prdata = slot_word(s_q.cfg, paddr[4:2]);
        end
      end else begin
        unique case (paddr)
          ADDR_CMD: s_d.prdata = {19'h0_0000, s_q.cmd_len, s_q.cmd_typ};
          ADDR_DATA_LO: s_d.prdata = s_q.cmd_dat[3:0];
          ADDR_DATA_HI: s_d.prdata = {8'h00, s_q.cmd_dat[6:4]};
          ADDR_RSP: s_d.prdata = {15'h0000, s_q.rsp_vld, 3'h0, s_q.rsp_len, s_q.rsp_typ};
          ADDR_RSP_LO: s_d.prdata = s_q.rsp_dat[3:0];
          ADDR_RSP_HI: s_d.prdata = {24'h00_0000, s_q.rsp_dat[4]};
          ADDR_FAN_PWR: s_d.prdata = s_q.fan_pwr;
          ADDR_BOOT: s_d.prdata = 32'h0000_0000;
          ADDR_TACH: s_d.prdata = s_q.tach_last;
          ADDR_STATUS: s_d.prdata = {s_q.show, 2'h0, s_q.held, 4'h0, s_q.fs_act};
          default: s_d.pslverr = 1'b1;
        endcase
        if (pwrite) begin
          s_d.prdata = 32'h0000_0000;
        end
      end
    end
    if (acc && pwrite && !s_q.pslverr) begin
      unique case (paddr)
        ADDR_CMD: begin
          s_d.cmd_typ = pwdata[7:0];
          s_d.cmd_len = pwdata[CMD_LEN_POS+:5];
          s_d.go = 1'b1;
        end
        ADDR_DATA_LO: s_d.cmd_dat[3:0] = pwdata;
        ADDR_DATA_HI: s_d.cmd_dat[6:4] = pwdata[23:0];
        ADDR_FAN_PWR: begin
          for (int f = 0; f < 4; f++) begin
            s_d.fan_pwr[f] = (pwdata[8*f+:8] > PWR_FULL) ? PWR_FULL : pwdata[8*f+:8];
          end
          // renewed fan power restarts the fail-safe watch
          s_d.fs_cnt = s_q.fs_tmo;
          s_d.fs_act = 4'h0;
        end
        ADDR_BOOT: begin
          if (pwdata[BOOT_SAVE_BIT]) begin
            s_d.boot = s_q.cfg;
          end
          if (pwdata[BOOT_LOAD_BIT]) begin
            s_d.cfg = s_q.boot;
          end
        end
        default: begin
        end
      endcase
    end
    if (acc && !pwrite && paddr == ADDR_RSP) begin
      s_d.rsp_vld = 1'b0;
    end

    // keypad: three-stage sync, a change counts when stages two and three agree
    s_d.key_s1 = key_in;
    s_d.key_s2 = s_q.key_s1;
    s_d.key_s3 = s_q.key_s2;
    s_d.held = nheld;
    s_d.evt_pr = pr & s_q.cfg.press_mask;
    s_d.evt_rl = rl & s_q.cfg.release_mask;
    s_d.evt_vld = |((pr & s_q.cfg.press_mask) | (rl & s_q.cfg.release_mask));

    // command execution, a cycle after the launch write
    if (s_q.go) begin
      s_d.rsp_typ = s_q.cmd_typ | RSP_ERR_OR;
      s_d.rsp_len = 5'h00;
      s_d.rsp_dat = 40'h00_0000_0000;
      s_d.rsp_vld = 1'b1;
      case (s_q.cmd_typ)
        CMD_LIVE: begin
          if (s_q.cmd_len == 5'h02 && d[0] < 8'h08 && d[1] == 8'h00) begin
            s_d.cfg.slot_en[sl] = 1'b0;
            s_d.cfg.slot_kind[sl] = ITEM_NONE;
            s_d.rsp_typ = s_q.cmd_typ | RSP_ACK_OR;
          end else if (s_q.cmd_len == 5'h07 && d[0] < 8'h08) begin
            // fan: 4 or 5 digits, 1 to 32 pulses; temperature: 3 or 5 digits, units 0/1
            slot_ok = (d[1] == 8'h01 && (d[3] == 8'h04 || d[3] == 8'h05) && d[6] >= 8'h01 &&
                       d[6] <= 8'h20) ||
                      (d[1] == 8'h02 && (d[3] == 8'h03 || d[3] == 8'h05) && d[6] <= 8'h01);
            if (slot_ok) begin
              s_d.cfg.slot_en[sl] = 1'b1;
              s_d.cfg.slot_kind[sl] = d[1][1:0];
              s_d.cfg.slot_idx[sl] = d[2][4:0];
              s_d.cfg.slot_dig[sl] = d[3][2:0];
              s_d.cfg.slot_col[sl] = d[4][3:0];
              s_d.cfg.slot_row[sl] = d[5][0];
              s_d.cfg.slot_aux[sl] = d[6][5:0];
              s_d.rsp_typ = s_q.cmd_typ | RSP_ACK_OR;
            end
          end
        end
        CMD_LCD: begin
          if (s_q.cmd_len == 5'h02 && d[0] < 8'h02) begin
            s_d.lcd_wr = 1'b1;
            s_d.lcd_sel = d[0][0];
            s_d.lcd_dat = d[1];
            s_d.rsp_typ = s_q.cmd_typ | RSP_ACK_OR;
          end
        end
        CMD_KEYMASK: begin
          if (s_q.cmd_len == 5'h02) begin
            s_d.cfg.press_mask = d[0][5:0];
            s_d.cfg.release_mask = d[1][5:0];
            s_d.rsp_typ = s_q.cmd_typ | RSP_ACK_OR;
          end
        end
        CMD_KEYPOLL: begin
          if (s_q.cmd_len == 5'h00) begin
            // unmasked view; events landing this very cycle go to the next poll
            s_d.rsp_dat[0] = {2'h0, s_q.held};
            s_d.rsp_dat[1] = {2'h0, s_q.since_pr};
            s_d.rsp_dat[2] = {2'h0, s_q.since_rl};
            s_d.rsp_len = 5'h03;
            s_d.since_pr = 6'h00;
            s_d.since_rl = 6'h00;
            s_d.rsp_typ = s_q.cmd_typ | RSP_ACK_OR;
          end
        end
        CMD_FAILSAFE: begin
          if (s_q.cmd_len == 5'h02) begin
            s_d.fs_mask = d[0][3:0];
            s_d.fs_tmo = d[1];
            s_d.fs_cnt = d[1];
            s_d.fs_act = 4'h0;
            s_d.rsp_typ = s_q.cmd_typ | RSP_ACK_OR;
          end
        end
        CMD_GLITCH: begin
          if (s_q.cmd_len == 5'h04) begin
            s_d.cfg.glitch = d[3:0];
            s_d.rsp_typ = s_q.cmd_typ | RSP_ACK_OR;
          end
        end
        CMD_FANQUERY: begin
          if (s_q.cmd_len == 5'h00) begin
            s_d.rsp_dat[3:0] = s_q.fan_pwr;
            s_d.rsp_dat[4] = {4'h0, s_q.fs_mask};
            s_d.rsp_len = 5'h05;
            s_d.rsp_typ = s_q.cmd_typ | RSP_ACK_OR;
          end
        end
        default: begin
        end
      endcase
    end
    // sticky poll flags: a new event beats the poll clear
    s_d.since_pr = s_d.since_pr | pr;
    s_d.since_rl = s_d.since_rl | rl;

    // time base: 100 glitch counts make one pwm period
    cnt_tick = (s_q.sub_cnt == COUNT_CYC - 17'h0_0001);
    s_d.sub_cnt = cnt_tick ? 17'h0_0000 : s_q.sub_cnt + 17'h0_0001;
    if (cnt_tick) begin
      s_d.pwm_cnt = (s_q.pwm_cnt == PWM_STEPS - 7'h01) ? 7'h00 : s_q.pwm_cnt + 7'h01;
    end
    eighth_tick = (s_q.tick_cnt == EIGHTH_CYC - 24'h00_0001);
    s_d.tick_cnt = eighth_tick ? 24'h00_0000 : s_q.tick_cnt + 24'h00_0001;
    if (eighth_tick) begin
      s_d.phase = s_q.phase + 2'h1;
      // timeout 0 leaves the watch disarmed
      if (s_q.fs_cnt == 8'h01) begin
        s_d.fs_act = s_q.fs_mask;
      end
      if (s_q.fs_cnt != 8'h00) begin
        s_d.fs_cnt = s_q.fs_cnt - 8'h01;
      end
    end

    // fans shown by an enabled slot get a full-power measuring window
    for (int k = 0; k < 8; k++) begin
      if (s_q.cfg.slot_en[k] && s_q.cfg.slot_kind[k] == ITEM_FAN) begin
        shown_fan[s_q.cfg.slot_idx[k][1:0]] = 1'b1;
      end
    end
    forced = (s_q.phase == 2'h0) ? shown_fan : 4'h0;

    s_d.tach_s1 = tach_in;
    s_d.tach_s2 = s_q.tach_s1;
    s_d.tach_s3 = s_q.tach_s2;
    s_d.tach_lvl = tlvl;
    for (int f = 0; f < 4; f++) begin
      s_d.fan_on[f] = s_q.fs_act[f] | forced[f] | ({1'b0, s_q.pwm_cnt} < s_q.fan_pwr[f]);
      if (s_d.fan_on[f] && !s_q.fan_on[f]) begin
        s_d.gl_cnt[f] = s_q.cfg.glitch[f];
      end else if (cnt_tick && s_q.gl_cnt[f] != 8'h00) begin
        s_d.gl_cnt[f] = s_q.gl_cnt[f] - 8'h01;
      end
      // edges count only on a powered fan past its blanking time
      if (tlvl[f] && !s_q.tach_lvl[f] && s_q.fan_on[f] && s_q.gl_cnt[f] == 8'h00 &&
          s_q.edges[f] != 8'hFF) begin
        s_d.edges[f] = s_q.edges[f] + 8'h01;
      end
      if (eighth_tick && s_q.phase == 2'h3) begin
        s_d.tach_last[f] = s_q.edges[f];
        s_d.edges[f] = 8'h00;
      end
    end

    // what each slot shows
    for (int k = 0; k < 8; k++) begin
      if (!s_q.cfg.slot_en[k] || s_q.cfg.slot_kind[k] == ITEM_NONE) begin
        s_d.show[k] = SHOW_OFF;
      end else if (s_q.cfg.slot_kind[k] == ITEM_FAN) begin
        s_d.show[k] = (s_q.tach_last[s_q.cfg.slot_idx[k][1:0]] == 8'h00) ? SHOW_SLOW : SHOW_VALUE;
      end else begin
        s_d.show[k] = temp_crc_err[s_q.cfg.slot_idx[k]] ? SHOW_ERR : SHOW_VALUE;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.cfg <= CFG_RESET;
      s_q.boot <= CFG_RESET;
      s_q.show <= 16'hFFFF;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign fan_drive = s_q.fan_on;
  assign lcd_wr = s_q.lcd_wr;
  assign lcd_ctrl_sel = s_q.lcd_sel;
  assign lcd_data = s_q.lcd_dat;
  assign key_evt_vld = s_q.evt_vld;
  assign key_press_evt = s_q.evt_pr;
  assign key_release_evt = s_q.evt_rl;
  assign slot_show = s_q.show;

endmodule : fdk_handler

// ===== fdk_pkg.sv
package fdk_pkg;
  // ==========================================================
  // apb register map (byte addresses)
  localparam logic [11:0] ADDR_CMD = 12'h000;
  localparam logic [11:0] ADDR_DATA_LO = 12'h004;
  localparam logic [11:0] ADDR_DATA_HI = 12'h008;
  localparam logic [11:0] ADDR_RSP = 12'h00C;
  localparam logic [11:0] ADDR_RSP_LO = 12'h010;
  localparam logic [11:0] ADDR_RSP_HI = 12'h014;
  localparam logic [11:0] ADDR_FAN_PWR = 12'h018;
  localparam logic [11:0] ADDR_BOOT = 12'h01C;
  localparam logic [11:0] ADDR_TACH = 12'h020;
  localparam logic [11:0] ADDR_STATUS = 12'h024;
  localparam logic [6:0] SLOT_PAGE = 7'h02;
  // ==========================================================
  // field positions
  localparam int CMD_LEN_POS = 8;
  localparam int RSP_VLD_POS = 16;
  localparam int BOOT_SAVE_BIT = 0;
  localparam int BOOT_LOAD_BIT = 1;
  localparam int ST_FS_POS = 0;
  localparam int ST_HELD_POS = 8;
  localparam int ST_SHOW_POS = 16;
  // ==========================================================
  // command codes and reply marks
  typedef enum logic [7:0] {
    CMD_LIVE = 8'h15,
    CMD_LCD = 8'h16,
    CMD_KEYMASK = 8'h17,
    CMD_KEYPOLL = 8'h18,
    CMD_FAILSAFE = 8'h19,
    CMD_GLITCH = 8'h1A,
    CMD_FANQUERY = 8'h1B
  } fdk_cmd_type;
  localparam logic [7:0] RSP_ACK_OR = 8'h40;
  localparam logic [7:0] RSP_ERR_OR = 8'hC0;
  // ==========================================================
  // keys and slot encodings
  localparam int key_north_bit = 0;
  localparam int key_accept_bit = 1;
  localparam int key_abort_bit = 2;
  localparam int key_west_bit = 3;
  localparam int key_east_bit = 4;
  localparam int key_south_bit = 5;
  localparam logic [1:0] ITEM_NONE = 2'h0;
  localparam logic [1:0] ITEM_FAN = 2'h1;
  localparam logic [1:0] ITEM_TEMP = 2'h2;
  localparam logic [1:0] SHOW_VALUE = 2'h0;
  localparam logic [1:0] SHOW_ERR = 2'h1;
  localparam logic [1:0] SHOW_SLOW = 2'h2;
  localparam logic [1:0] SHOW_OFF = 2'h3;
  localparam logic [7:0] PWR_FULL = 8'h64;
  localparam logic [6:0] PWM_STEPS = 7'h64;
  // ==========================================================
  // timing
  localparam real CLK_NS = 10.0;
  localparam real GLITCH_COUNT_US = 552.5;
  localparam real TICK_S = 0.125;
  localparam int GLITCH_COUNT_CYC = int'(GLITCH_COUNT_US * 1000.0 / CLK_NS);
  localparam int TICK_CYC = int'(TICK_S * 1.0e9 / CLK_NS);
  // ==========================================================
  // boot-state configuration
  typedef struct packed {
    logic [7:0] slot_en;
    logic [7:0][1:0] slot_kind;
    logic [7:0][4:0] slot_idx;
    logic [7:0][2:0] slot_dig;
    logic [7:0][3:0] slot_col;
    logic [7:0] slot_row;
    logic [7:0][5:0] slot_aux;
    logic [5:0] press_mask;
    logic [5:0] release_mask;
    logic [3:0][7:0] glitch;
  } fdk_cfg_type;
  localparam fdk_cfg_type CFG_RESET = '{
    slot_en: 8'h00, slot_kind: 16'h0000, slot_idx: 40'h00_0000_0000,
    slot_dig: 24'h00_0000, slot_col: 32'h0000_0000, slot_row: 8'h00,
    slot_aux: 48'h0000_0000_0000, press_mask: 6'h3F, release_mask: 6'h3F,
    glitch: 32'h0101_0101};
endpackage : fdk_pkg

// ===== fdk_handler_properties.sv
`timescale 1ns/1ps
// ==========================================================
// port checker
module fdk_handler_properties
  import fdk_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] key_in,
  input wire logic lcd_wr,
  input wire logic key_evt_vld,
  input wire logic [5:0] key_press_evt,
  input wire logic [5:0] key_release_evt,
  input wire logic [15:0] slot_show
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // sequences
  sequence apb_setup;
    psel && !penable;
  endsequence
  // only valid targets are sent, so every two-byte launch must reach the controller
  sequence lcd_launch;
    psel && penable && pready && pwrite && paddr == ADDR_CMD && pwdata[12:0] == {5'h02, CMD_LCD};
  endsequence
  // ==========================================================
  // assertions
  rst_show_a: assert property ($rose(presetn) |-> slot_show == 16'hFFFF)
    else $error("slots not off after reset");
  ready_wait_a: assert property (apb_setup |=> pready)
    else $error("answer not in first access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_quiet_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer malformed");
  err_unmapped_a: assert property (psel && !penable && paddr == 12'h030 |=> pslverr)
    else $error("unmapped access not refused");
  lcd_pulse_a: assert property (lcd_launch |-> ##2 lcd_wr ##1 !lcd_wr)
    else $error("controller write pulse wrong");
  key_flag_a: assert property (key_evt_vld == ((key_press_evt | key_release_evt) != 6'h00))
    else $error("event flag and bits disagree");
  key_press_a: assert property ((key_press_evt & ~$past(key_in, 3)) == 6'h00)
    else $error("press of a key not held");
  key_rel_a: assert property ((key_release_evt & $past(key_in, 3)) == 6'h00)
    else $error("release of a key still held");
endmodule : fdk_handler_properties

bind fdk_handler fdk_handler_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .key_in, .lcd_wr, .key_evt_vld, .key_press_evt,
  .key_release_evt, .slot_show);

// ===== fdk_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// host side: apb master sending whole command packets
module fdk_host_model
  import fdk_pkg::*;
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // entered just after a rising edge; the answer is taken at the rising edge
  // that samples pready high, and only then is the request released
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask : xfer
  // data words first, the type/length word launches the packet
  task automatic cmd(input logic [7:0] c, input logic [4:0] n, input logic [55:0] p,
                     output logic [31:0] rsp);
    logic [31:0] q;
    logic e;
    xfer(1'b1, ADDR_DATA_LO, p[31:0], q, e);
    xfer(1'b1, ADDR_DATA_HI, {8'h00, p[55:32]}, q, e);
    xfer(1'b1, ADDR_CMD, {19'h00000, n, c}, q, e);
    xfer(1'b0, ADDR_RSP, 32'h0000_0000, rsp, e);
  endtask : cmd
endmodule : fdk_host_model

// ===== tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb
  import fdk_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, lcd_wr, lcd_ctrl_sel, key_evt_vld;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, temp_crc_err;
  logic [5:0] key_in, key_press_evt, key_release_evt;
  logic [3:0] tach_in, fan_drive;
  logic [7:0] lcd_data;
  logic [15:0] slot_show;
  int check_count = 0;
  int miscompares = 0;
  int lcd_cnt = 0;
  always #5 pclk = ~pclk;
  always @(negedge pclk) if (lcd_wr === 1'b1) lcd_cnt++;
  // ==========================================================
  // short eighth tick (500) and glitch count keep the run brief
  fdk_handler #(.COUNT_CYC(17'h00004), .EIGHTH_CYC(24'h0001F4)) dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .key_in, .tach_in, .temp_crc_err,
    .fan_drive, .lcd_wr, .lcd_ctrl_sel, .lcd_data, .key_evt_vld, .key_press_evt, .key_release_evt,
    .slot_show);
  fdk_host_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  // ==========================================================
  // helpers
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    host.xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    host.xfer(1'b1, a, d, q, e);
  endtask : wr
  task automatic send(input logic [7:0] c, input logic [4:0] n, input logic [55:0] p, input logic [31:0] x);
    logic [31:0] q;
    host.cmd(c, n, p, q);
    `CHK("reply", x, q)
  endtask : send
  task automatic key_step(input logic [5:0] k, input logic v, input logic [5:0] p, input logic [5:0] r);
    logic seen;
    logic [5:0] sp, sr;
    seen = 1'b0;
    sp = 6'h00;
    sr = 6'h00;
    key_in <= k;
    repeat (12) begin
      @(negedge pclk);
      if (key_evt_vld === 1'b1) begin
        seen = 1'b1;
        sp = key_press_evt;
        sr = key_release_evt;
      end
    end
    @(posedge pclk);
    `CHK("key event", v, seen)
    `CHK("press bits", p, sp)
    `CHK("release bits", r, sr)
  endtask : key_step
  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    `CHK("slot_show", 16'hFFFF, slot_show)
    rd(ADDR_STATUS, q);
    `CHK("status", 32'hFFFF_0000, q)
    host.xfer(1'b0, 12'h030, 32'h0000_0000, q, e);
    `CHK("unmapped", 1'b1, e)
  endtask : t_reset
  task automatic t_live();
    logic [31:0] q;
    int n;
    temp_crc_err <= 32'h8000_0000;
    send(CMD_LIVE, 5'h07, {8'h20, 8'h01, 8'h0C, 8'h04, 8'h02, 8'h01, 8'h03}, 32'h0001_0055);
    send(CMD_LIVE, 5'h07, {8'h01, 8'h00, 8'h0B, 8'h05, 8'h1F, 8'h02, 8'h05}, 32'h0001_0055);
    send(CMD_LIVE, 5'h07, {8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h01, 8'h00}, 32'h0001_00D5);
    send(CMD_LIVE, 5'h05, {8'h01, 8'h00, 8'h00, 8'h04, 8'h00, 8'h01, 8'h00}, 32'h0001_00D5);
    rd(12'h04C, q);
    `CHK("slot3", 32'hA204_C120, q)
    n = 0;
    repeat (2000) @(posedge pclk);
    // any window of four eighth ticks (2000 cycles) holds one forced span, at most 500 cycles of drive
    repeat (2000) begin
      @(negedge pclk);
      if (fan_drive[2] === 1'b1) n++;
    end
    @(posedge pclk);
    `CHK("forced span", 1'b1, n > 0 && n <= 500)
    `CHK("slot states", 16'hF7BF, slot_show)
    send(CMD_LIVE, 5'h02, 56'h0000_0000_0000_03, 32'h0001_0055);
    send(CMD_LIVE, 5'h02, 56'h0000_0000_0000_05, 32'h0001_0055);
    temp_crc_err <= 32'h0000_0000;
    `CHK("slots off", 16'hFFFF, slot_show)
  endtask : t_live
  task automatic t_lcd();
    send(CMD_LCD, 5'h02, {40'h00_0000_0000, 8'hA5, 8'h00}, 32'h0001_0056);
    `CHK("data sel", 1'b0, lcd_ctrl_sel)
    `CHK("data byte", 8'hA5, lcd_data)
    send(CMD_LCD, 5'h02, {40'h00_0000_0000, 8'h3C, 8'h01}, 32'h0001_0056);
    `CHK("ctrl sel", 1'b1, lcd_ctrl_sel)
    `CHK("ctrl byte", 8'h3C, lcd_data)
    `CHK("write pulses", 2, lcd_cnt)
  endtask : t_lcd
  task automatic t_keys();
    logic [31:0] q;
    key_step(6'h01, 1'b1, 6'h01, 6'h00);
    key_step(6'h00, 1'b1, 6'h00, 6'h01);
    send(CMD_KEYMASK, 5'h02, {40'h00_0000_0000, 8'h00, 8'h20}, 32'h0001_0057);
    key_step(6'h03, 1'b0, 6'h00, 6'h00);
    key_step(6'h23, 1'b1, 6'h20, 6'h00);
    key_step(6'h03, 1'b0, 6'h00, 6'h00);
    send(CMD_KEYPOLL, 5'h00, 56'h0000_0000_0000_00, 32'h0001_0358);
    rd(ADDR_RSP_LO, q);
    `CHK("poll", 32'h0021_2303, q)
    send(CMD_KEYPOLL, 5'h00, 56'h0000_0000_0000_00, 32'h0001_0358);
    rd(ADDR_RSP_LO, q);
    `CHK("poll again", 32'h0000_0003, q)
    key_step(6'h00, 1'b0, 6'h00, 6'h00);
    // save the narrow masks, open them, restore: the press must stay masked
    wr(ADDR_BOOT, 32'h0000_0001);
    send(CMD_KEYMASK, 5'h02, {40'h00_0000_0000, 8'h3F, 8'h3F}, 32'h0001_0057);
    wr(ADDR_BOOT, 32'h0000_0002);
    key_step(6'h01, 1'b0, 6'h00, 6'h00);
  endtask : t_keys
  task automatic t_fan();
    logic [31:0] q;
    wr(ADDR_FAN_PWR, 32'h0000_0032);
    send(CMD_GLITCH, 5'h04, {24'h00_0000, 32'h0101_0102}, 32'h0001_005A);
    send(CMD_FAILSAFE, 5'h02, {40'h00_0000_0000, 8'h02, 8'h05}, 32'h0001_0059);
    rd(ADDR_STATUS, q);
    `CHK("safe idle", 4'h0, q[3:0])
    // fans 0 and 1 both toggle their tach lines; only the powered fan 0 may count
    repeat (270) begin
      repeat (16) @(posedge pclk);
      tach_in <= tach_in ^ 4'h3;
    end
    rd(ADDR_TACH, q);
    `CHK("tach powered", 1'b1, q[7:0] != 8'h00)
    `CHK("tach unpowered", 8'h00, q[15:8])
    rd(ADDR_STATUS, q);
    `CHK("safe fired", 4'h5, q[3:0])
    `CHK("fan forced", 1'b1, fan_drive[2])
    send(CMD_FANQUERY, 5'h00, 56'h0000_0000_0000_00, 32'h0001_055B);
    rd(ADDR_RSP_LO, q);
    `CHK("powers", 32'h0000_0032, q)
    rd(ADDR_RSP_HI, q);
    `CHK("safe mask", 8'h05, q[7:0])
    wr(ADDR_FAN_PWR, 32'h0000_0000);
    rd(ADDR_STATUS, q);
    `CHK("safe cleared", 4'h0, q[3:0])
  endtask : t_fan
  // ==========================================================
  // main sequence and watchdog (the run needs about 10k cycles)
  initial begin
    presetn = 1'b0;
    key_in = 6'h00;
    tach_in = 4'h0;
    temp_crc_err = 32'h0000_0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_live();
    t_lcd();
    t_keys();
    t_fan();
    end_of_test();
  end
  initial begin
    repeat (50000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end
endmodule : tb
